// >>> core/rops_top.sv
// Purpose: Avalon-MM register file of the output pin selectors and the
//          pin multiplexer it steers.
// Assumes: Single clk at 100 MHz, synchronous reset, master holds requests.
// Notes:   Every access answers one cycle after it is first seen.
module rops_top
	import rops_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0 // Smallest package variant
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [ROPS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [ROPS_DATA_W-1:0] avs_writedata,
	output logic [ROPS_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [ROPS_FUNC_N-1:0] periph_func,
	output logic [ROPS_NUM_PINS-1:0] pin_drive,
	output logic [ROPS_NUM_PINS-1:0] pin_claim
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		rops_bus_state_t state; // Bus answer state
		logic waitreq; // Registered waitrequest
		logic [ROPS_DATA_W-1:0] rdata; // Registered read data
		logic [ROPS_NUM_PINS-1:0][ROPS_SEL_W-1:0] sel; // Selector fields
	} rops_top_state_t;

	localparam rops_top_state_t ROPS_TOP_RESET = '{
		state: ROPS_IDLE,
		waitreq: 1'b1,
		rdata: '0,
		sel: {ROPS_NUM_PINS{ROPS_SEL_RESET}}
	};

	rops_top_state_t q; // Current state
	rops_top_state_t d; // Next state
	logic [3:0] reg_idx; // Decoded register index

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Map a byte address to a register index
	function automatic logic [3:0] rops_decode(input logic [7:0] addr);
		case (addr)
			ROPS_OFF_PINS_8_9: rops_decode = 4'h0;
			ROPS_OFF_PINS_10_11: rops_decode = 4'h1;
			ROPS_OFF_PINS_12_13: rops_decode = 4'h2;
			ROPS_OFF_PINS_14_15: rops_decode = 4'h3;
			ROPS_OFF_PINS_16_17: rops_decode = 4'h4;
			ROPS_OFF_PINS_18_19: rops_decode = 4'h5;
			ROPS_OFF_PINS_20_21: rops_decode = 4'h6;
			default: rops_decode = ROPS_REG_NONE;
		endcase
	endfunction : rops_decode

	// Build the 16-bit image of one register, unused bits zero
	function automatic logic [15:0] rops_image(
		input logic [ROPS_NUM_PINS-1:0][ROPS_SEL_W-1:0] s,
		input logic [3:0] idx
	);
		int even;
		even = 2 * int'(idx);
		rops_image = {2'b00, s[even+1], 2'b00, s[even]};
	endfunction : rops_image

	assign reg_idx = rops_decode(avs_address);

	////////////////////////////////////////////////////////////////////////
	// Bus slave and selector registers
	always_comb begin
		int even;
		even = 0;
		d = q;
		case (q.state)
			// Take a request, answer in the next cycle
			ROPS_IDLE: begin
				if (avs_read || avs_write) begin
					d.state = ROPS_ANSWER;
					d.waitreq = 1'b0;
					d.rdata = '0;
					if (avs_read && reg_idx != ROPS_REG_NONE) begin
						d.rdata = {16'h0000, rops_image(q.sel, reg_idx)};
					end
				end
			end
			// Waitrequest is low at this edge: the write lands here
			ROPS_ANSWER: begin
				d.state = ROPS_IDLE;
				d.waitreq = 1'b1;
				if (avs_write && reg_idx != ROPS_REG_NONE) begin
					even = 2 * int'(reg_idx);
					if (avs_byteenable[0]) begin
						d.sel[even] = avs_writedata[ROPS_EVEN_LSB +: ROPS_SEL_W];
					end
					if (avs_byteenable[1]) begin
						d.sel[even+1] = avs_writedata[ROPS_ODD_LSB +: ROPS_SEL_W];
					end
				end
			end
			// Illegal encoding, return to idle
			default: begin
				d.state = ROPS_IDLE;
				d.waitreq = 1'b1;
			end
		endcase
		// Pin 15 field does not exist in the small package
		if (SMALL_PACKAGE) begin
			d.sel[ROPS_SMALL_IDX] = ROPS_SEL_NONE;
		end
	end

	// Register the state, selectors clear on reset
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= ROPS_TOP_RESET;
		end else begin
			q <= d;
		end
	end

	assign avs_readdata = q.rdata;
	assign avs_waitrequest = q.waitreq;

	////////////////////////////////////////////////////////////////////////
	// Pin multiplexer
	rops_sel_if sel_bus ();

	assign sel_bus.sel = q.sel;
	assign sel_bus.func = periph_func;

	rops_pin_mux u_mux (
		.clk(clk),
		.reset(reset),
		.bus(sel_bus)
	);

	// Both come straight from the multiplexer's flip-flops
	assign pin_drive = sel_bus.pin_out;
	assign pin_claim = sel_bus.pin_claim;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Accepted write to the first register, odd lane enabled
	sequence s_wr_odd;
		avs_write && !avs_waitrequest && avs_byteenable[1]
			&& avs_address == ROPS_OFF_PINS_8_9;
	endsequence

	// Accepted read
	sequence s_rd_done;
		avs_read && !avs_waitrequest;
	endsequence

	a_wait_one: assert property (
		q.state == ROPS_IDLE && (avs_read || avs_write)
		|=> !avs_waitrequest ##1 avs_waitrequest
	) else $error("slave did not answer in one cycle");

	a_write_odd: assert property (
		s_wr_odd |=> q.sel[1] == $past(avs_writedata[13:8])
	) else $error("odd pin field not written from bits 13:8");

	a_read_zero: assert property (
		s_rd_done |-> avs_readdata[31:14] == '0 && avs_readdata[7:6] == '0
	) else $error("reserved bits read nonzero");

	a_reset_clear: assert property (
		$past(reset) |-> q.sel == '0
	) else $error("selectors not cleared by reset");

	a_small_pin: assert property (
		SMALL_PACKAGE |-> q.sel[ROPS_SMALL_IDX] == ROPS_SEL_NONE
	) else $error("absent pin 15 field holds a value");

endmodule : rops_top

// >>> core/rops_pkg.sv
// Purpose: Shared constants and types for the remappable output pin select.
// Assumes: 100 MHz clk, synchronous active-high reset, Avalon-MM slave.
// Notes:   Fourteen 6-bit selectors, pins 8 to 21, two per 16-bit register.
// Functional notes
// - Two 6-bit fields: odd 13:8, even 5:0
// - Selector value n routes function n out, zero routes nothing
// - Bits 15:14 and 7:6 read zero
// - Selector bits read/write, cleared at reset
// - Small package: pin 15 field absent
package rops_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int ROPS_NUM_REGS = 7; // Output mapping registers
	localparam int ROPS_NUM_PINS = 14; // Pins 8 to 21
	localparam int ROPS_FIRST_PIN = 8; // Number of the lowest pin served
	localparam int ROPS_SEL_W = 6; // Selector field width
	localparam int ROPS_FUNC_N = 64; // Peripheral function levels, a field names 1 to 63
	localparam int ROPS_DATA_W = 32; // Avalon data width
	localparam int ROPS_ADDR_W = 8; // Avalon byte address width

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] ROPS_OFF_PINS_8_9 = 8'h00;
	localparam logic [7:0] ROPS_OFF_PINS_10_11 = 8'h04;
	localparam logic [7:0] ROPS_OFF_PINS_12_13 = 8'h08;
	localparam logic [7:0] ROPS_OFF_PINS_14_15 = 8'h0c;
	localparam logic [7:0] ROPS_OFF_PINS_16_17 = 8'h10;
	localparam logic [7:0] ROPS_OFF_PINS_18_19 = 8'h14;
	localparam logic [7:0] ROPS_OFF_PINS_20_21 = 8'h18;
	localparam logic [3:0] ROPS_REG_NONE = 4'hf; // Unmapped address

	////////////////////////////////////////////////////////////////////////
	// Field layout inside each register
	localparam int ROPS_ODD_LSB = 8; // Odd pin field 13:8
	localparam int ROPS_EVEN_LSB = 0; // Even pin field 5:0
	localparam int ROPS_SMALL_PIN = 15; // Pin dropped in the small package
	localparam logic [5:0] ROPS_SEL_RESET = 6'h00; // Selector after reset
	localparam logic [5:0] ROPS_SEL_NONE = 6'h00; // No function routed

	////////////////////////////////////////////////////////////////////////
	// Bus answer states, Gray along idle -> answer -> idle
	typedef enum logic [1:0] {
		ROPS_IDLE = 2'b00,
		ROPS_ANSWER = 2'b01
	} rops_bus_state_t;

	// Index of a pin's selector in the packed selector array
	localparam int ROPS_SMALL_IDX = ROPS_SMALL_PIN - ROPS_FIRST_PIN;

endpackage : rops_pkg

// >>> core/rops_sel_if.sv
// Purpose: Carries selectors and function levels from the register file
//          to the pin multiplexer, and the pin levels back.
// Assumes: Both ends on clk.
// Notes:   Plain wires, no timing of its own.
interface rops_sel_if;
	import rops_pkg::*;

	logic [ROPS_NUM_PINS-1:0][ROPS_SEL_W-1:0] sel; // Selector per pin
	logic [ROPS_FUNC_N-1:0] func; // Peripheral output function levels
	logic [ROPS_NUM_PINS-1:0] pin_out; // Level driven on each pin
	logic [ROPS_NUM_PINS-1:0] pin_claim; // Pin taken from the port

	// Register side
	modport ctrl (output sel, output func, input pin_out, input pin_claim);
	// Multiplexer side
	modport mux (input sel, input func, output pin_out, output pin_claim);

endinterface : rops_sel_if

// >>> core/rops_pin_mux.sv
// Purpose: Routes one peripheral function onto each remappable pin.
// Assumes: Selectors and function levels come from logic on clk.
// Notes:   One register stage, so pin levels lag selector changes by 1.
module rops_pin_mux
	import rops_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	rops_sel_if.mux bus
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [ROPS_NUM_PINS-1:0] pin; // Registered pin level
		logic [ROPS_NUM_PINS-1:0] claim; // Registered pin ownership
	} rops_mux_state_t;

	rops_mux_state_t q; // Current state
	rops_mux_state_t d; // Next state

	// Pick function n for each pin, nothing for zero
	always_comb begin
		d = q;
		for (int i = 0; i < ROPS_NUM_PINS; i++) begin
			if (bus.sel[i] != ROPS_SEL_NONE) begin
				d.pin[i] = bus.func[bus.sel[i]];
				d.claim[i] = 1'b1;
			end else begin
				d.pin[i] = 1'b0;
				d.claim[i] = 1'b0;
			end
		end
	end

	// Register the pin stage
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus.pin_out = q.pin;
	assign bus.pin_claim = q.claim;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	logic route_ref; // Expected level for the top pin
	assign route_ref = bus.func[bus.sel[ROPS_NUM_PINS-1]];

	a_route_pin: assert property (
		bus.sel[ROPS_NUM_PINS-1] != ROPS_SEL_NONE
		|=> bus.pin_out[ROPS_NUM_PINS-1] == $past(route_ref)
	) else $error("pin level does not follow selected function");

	a_zero_idle: assert property (
		bus.sel[0] == ROPS_SEL_NONE |=> !bus.pin_claim[0] && !bus.pin_out[0]
	) else $error("unselected pin still claimed or driven");

	a_claim_even: assert property (
		bus.sel[0] != ROPS_SEL_NONE |=> bus.pin_claim[0]
	) else $error("even pin not claimed by its field");

endmodule : rops_pin_mux

// >>> verif/rops_top_tb.sv
// Purpose: Self-checking bench for the output pin selector block.
// Assumes: Small package build, Avalon-MM master held until waitrequest low.
// Notes:   Driver notes expectations in queues; a monitor compares them.
module rops_top_tb
	import rops_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Signals
	logic clk = 1'b0; // 100 MHz clock
	logic reset = 1'b1; // Synchronous reset
	logic [ROPS_ADDR_W-1:0] avs_address = '0; // Byte address
	logic avs_read = 1'b0; // Read request
	logic avs_write = 1'b0; // Write request
	logic [3:0] avs_byteenable = '0; // Lane enables
	logic [ROPS_DATA_W-1:0] avs_writedata = '0; // Write data
	logic [ROPS_DATA_W-1:0] avs_readdata; // Read data
	logic avs_waitrequest; // Wait request
	logic [ROPS_FUNC_N-1:0] periph_func = '0; // Function levels
	logic [ROPS_NUM_PINS-1:0] pin_drive; // Pin levels
	logic [ROPS_NUM_PINS-1:0] pin_claim; // Pins taken
	logic pin_req = 1'b0; // Marks a pin sample for the monitor
	logic [5:0] exp_sel [ROPS_NUM_PINS]; // Selector model
	logic [31:0] rd_q [$]; // Expected read data
	logic [31:0] pin_q [$]; // Expected {claim, drive}
	int errors = 0;
	int samples_checked = 0;

	always #5 clk = ~clk;

	// Device under test in its small package form
	rops_top #(.SMALL_PACKAGE(1'b1)) u_dut (.clk(clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .periph_func(periph_func),
		.pin_drive(pin_drive), .pin_claim(pin_claim));

	////////////////////////////////////////////////////////////////////////
	// Comparison and closing
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task test_done;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// Monitor: read data at the accepting edge, pins when marked
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			check(avs_readdata, rd_q.pop_front());
		end
		if (pin_req) begin
			check({2'b0, pin_claim, 2'b0, pin_drive}, pin_q.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drivers
	// One Avalon access, held until waitrequest is sampled low
	task bus(input logic wr, input int k, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		avs_address <= ROPS_OFF_PINS_8_9 + 8'(4 * k);
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		if (!wr) begin
			// Unmapped places and unused bits read zero
			rd_q.push_back(k > 6 ? 32'h0 :
				{18'h0, exp_sel[2*k+1], 2'b0, exp_sel[2*k]});
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			errors++;
			test_done();
		end
		// Model the write, the pin 15 field stays absent
		if (wr && k <= 6 && be[0]) exp_sel[2*k] = d[5:0];
		if (wr && k <= 6 && be[1] && k != 3) exp_sel[2*k+1] = d[13:8];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus

	// New function levels, then one pin sample three edges later
	task pins(input logic [63:0] f);
		logic [31:0] e;
		periph_func <= f;
		repeat (2) @(posedge clk);
		e = '0;
		for (int i = 0; i < ROPS_NUM_PINS; i++) begin
			e[16+i] = exp_sel[i] != 6'h00;
			e[i] = exp_sel[i] != 6'h00 ? f[exp_sel[i]] : 1'b0;
		end
		pin_q.push_back(e);
		pin_req <= 1'b1;
		@(posedge clk);
		pin_req <= 1'b0;
	endtask : pins

	// Reset for two cycles and clear the model
	task do_reset;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (exp_sel[i]) exp_sel[i] = 6'h00;
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h6577));
		do_reset();
		// Reset values of every register and pin
		for (int k = 0; k < 7; k++) bus(1'b0, k, 32'h0, 4'h0);
		pins({$urandom, $urandom});
		// Random data over reserved bits and random lanes
		repeat (4) begin
			for (int k = 0; k < 7; k++) begin
				bus(1'b1, k, $urandom, 4'($urandom));
			end
			for (int k = 0; k < 7; k++) bus(1'b0, k, 32'h0, 4'h0);
			pins({$urandom, $urandom});
			pins({$urandom, $urandom});
		end
		// Selector zero, the absent field and all functions high
		bus(1'b1, 0, 32'h0000_0000, 4'hf);
		bus(1'b1, 3, 32'hffff_ffff, 4'hf);
		bus(1'b0, 3, 32'h0, 4'h0);
		pins({64{1'b1}});
		pins(64'h0);
		// Unmapped place: write ignored, reads zero
		bus(1'b1, 7, 32'hffff_ffff, 4'hf);
		bus(1'b0, 7, 32'h0, 4'h0);
		for (int k = 0; k < 7; k++) bus(1'b0, k, 32'h0, 4'h0);
		// Reset in mid-run clears every selector
		do_reset();
		for (int k = 0; k < 7; k++) bus(1'b0, k, 32'h0, 4'h0);
		pins({64{1'b1}});
		test_done();
	end

endmodule : rops_top_tb
